/* File: vio_router_pkg.sv */
`default_nettype none
package vio_router_pkg;
  // Channel counts and signal code space
  localparam int NUM_VIN = 4;
  localparam int NUM_UOUT = 2;
  localparam int SIG_CODE_W = 8;
  localparam int NUM_OUT_SIGS = 256;
  localparam int FUNC_CODE_W = 8;
  localparam int NUM_IN_FUNCS = 256;
  localparam logic [SIG_CODE_W-1:0] CODE_CONST_OFF = 8'h80;
  localparam logic [FUNC_CODE_W-1:0] FUNC_NOT_USED = 8'h00;
  // Dead time in ms, and cycles per ms at the 25 MHz clock
  localparam int CLK_HZ = 25000000;
  localparam int DEAD_MS_MAX = 250;
  localparam int DEAD_MS_W = 8;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int MS_CNT_W = 15;
  // APB register map, one word per register
  localparam logic [7:0] VIN_BASE = 8'h00;
  localparam logic [7:0] VIN_STRIDE = 8'h04;
  localparam logic [7:0] UOUT_BASE = 8'h10;
  localparam logic [7:0] STATUS_ADDR = 8'h20;
  // Virtual input word fields
  localparam int VIN_FUNC_LSB = 0;
  localparam int VIN_SRC_LSB = 8;
  localparam int VIN_DEAD_LSB = 16;
  localparam int VIN_INV_BIT = 24;
  localparam int VIN_SHOT_BIT = 25;
  // User output word fields
  localparam int UO_SRCA_LSB = 0;
  localparam int UO_SRCB_LSB = 8;
  localparam int UO_INVA_BIT = 16;
  localparam int UO_INVB_BIT = 17;
  localparam int UO_OR_BIT = 18;

  typedef struct packed {
    logic shot;
    logic inv;
    logic [DEAD_MS_W-1:0] dead_ms;
    logic [SIG_CODE_W-1:0] src;
    logic [FUNC_CODE_W-1:0] func;
  } vin_cfg_t;

  typedef struct packed {
    logic use_or;
    logic inv_b;
    logic inv_a;
    logic [SIG_CODE_W-1:0] src_b;
    logic [SIG_CODE_W-1:0] src_a;
  } uout_cfg_t;

  localparam vin_cfg_t VIN_RESET = '{shot: 1'b0, inv: 1'b0, dead_ms: 8'h00,
                                     src: CODE_CONST_OFF, func: FUNC_NOT_USED};
  localparam uout_cfg_t UOUT_RESET = '{use_or: 1'b1, inv_b: 1'b0, inv_a: 1'b0,
                                       src_b: CODE_CONST_OFF, src_a: CODE_CONST_OFF};
endpackage
`default_nettype wire

/* File: vio_router.sv */
`default_nettype none
module vio_router (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [vio_router_pkg::NUM_OUT_SIGS-1:0] OUT_SIGS,
  output logic [vio_router_pkg::NUM_IN_FUNCS-1:0] IN_FUNCS,
  output logic [vio_router_pkg::NUM_UOUT-1:0] USER_OUT,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  import vio_router_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  vin_cfg_t vin_cfg_reg [NUM_VIN];
  uout_cfg_t uout_cfg_reg [NUM_UOUT];
  logic [NUM_VIN-1:0] vin_level_reg;
  logic [NUM_VIN-1:0] vin_out_reg;

  // Address decode
  wire logic setup = PSEL && !PENABLE;
  // A write lands only at the access edge where ready is seen high
  wire logic wr_go = PSEL && PENABLE && PREADY && PWRITE;
  wire logic [3:0] vin_hit;
  wire logic [1:0] uout_hit;
  wire logic stat_hit = (PADDR == STATUS_ADDR);
  genvar g;
  generate
    for (g = 0; g < NUM_VIN; g++) begin : g_vdec
      assign vin_hit[g] = (PADDR == VIN_BASE + 8'(g) * VIN_STRIDE);
    end
    for (g = 0; g < NUM_UOUT; g++) begin : g_udec
      assign uout_hit[g] = (PADDR == UOUT_BASE + 8'(g) * VIN_STRIDE);
    end
  endgenerate
  wire logic any_hit = (|vin_hit) || (|uout_hit) || stat_hit;

  // Read mux, with packed fields placed at their word positions
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < NUM_VIN; i++) begin
      if (vin_hit[i]) begin
        rd_mux = {6'h00, vin_cfg_reg[i]};
      end
    end
    for (int i = 0; i < NUM_UOUT; i++) begin
      if (uout_hit[i]) begin
        rd_mux = {13'h0000, uout_cfg_reg[i]};
      end
    end
    if (stat_hit) begin
      rd_mux = {24'h00_0000, USER_OUT, 2'b00, vin_out_reg};
    end
  end

  // Zero-wait APB: answer in the access cycle; unmapped gives PSLVERR
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup && !any_hit;
      PRDATA <= (setup && !PWRITE) ? rd_mux : 32'h0000_0000;
    end
  end

  // Writes latch at the completing access edge; unmapped words are ignored
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      for (int i = 0; i < NUM_VIN; i++) vin_cfg_reg[i] <= VIN_RESET;
      for (int i = 0; i < NUM_UOUT; i++) uout_cfg_reg[i] <= UOUT_RESET;
    end else if (wr_go) begin
      for (int i = 0; i < NUM_VIN; i++) begin
        if (vin_hit[i]) vin_cfg_reg[i] <= vin_cfg_t'(PWDATA[25:0]);
      end
      for (int i = 0; i < NUM_UOUT; i++) begin
        if (uout_hit[i]) uout_cfg_reg[i] <= uout_cfg_t'(PWDATA[18:0]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared millisecond tick for all dead-time counters
  logic [MS_CNT_W-1:0] ms_cnt_reg;
  wire logic ms_tick = (ms_cnt_reg == MS_CNT_W'(CYC_PER_MS - 1));
  always_ff @(posedge CLK) begin
    if (!RESET_N) ms_cnt_reg <= '0;
    else ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Virtual input channels
  logic [DEAD_MS_W-1:0] dead_cnt_reg [NUM_VIN];
  generate
    for (g = 0; g < NUM_VIN; g++) begin : g_vin
      // Select then invert the trigger
      wire logic raw = OUT_SIGS[vin_cfg_reg[g].src];
      wire logic trig = raw ^ vin_cfg_reg[g].inv;
      // ON must persist the dead time; quantised to the ms tick, so up to 1 ms early
      wire logic dead_done = (dead_cnt_reg[g] >= vin_cfg_reg[g].dead_ms);
      wire logic level_next = trig && dead_done;
      wire logic rise = level_next && !vin_level_reg[g];
      always_ff @(posedge CLK) begin
        if (!RESET_N) begin
          dead_cnt_reg[g] <= '0;
          vin_level_reg[g] <= 1'b0;
          vin_out_reg[g] <= 1'b0;
        end else begin
          if (!trig) dead_cnt_reg[g] <= '0; // OFF edges pass at once
          else if (ms_tick && !dead_done) dead_cnt_reg[g] <= dead_cnt_reg[g] + 1'b1;
          vin_level_reg[g] <= level_next;
          // One clock pulse per ON edge when one-shot is set
          vin_out_reg[g] <= vin_cfg_reg[g].shot ? rise : level_next;
        end
      end
    end
  endgenerate

  // Route each channel to its function; function 0 is never driven
  logic [NUM_IN_FUNCS-1:0] func_next;
  always_comb begin
    func_next = '0;
    for (int i = 0; i < NUM_VIN; i++) begin
      if (vin_cfg_reg[i].func != FUNC_NOT_USED) begin
        func_next[vin_cfg_reg[i].func] = func_next[vin_cfg_reg[i].func] | vin_out_reg[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // User output channels
  logic [NUM_UOUT-1:0] uout_next;
  generate
    for (g = 0; g < NUM_UOUT; g++) begin : g_uo
      wire logic a = OUT_SIGS[uout_cfg_reg[g].src_a] ^ uout_cfg_reg[g].inv_a;
      wire logic b = OUT_SIGS[uout_cfg_reg[g].src_b] ^ uout_cfg_reg[g].inv_b;
      assign uout_next[g] = uout_cfg_reg[g].use_or ? (a | b) : (a & b);
    end
  endgenerate

  // Registered outputs, refreshed every clock
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      IN_FUNCS <= '0;
      USER_OUT <= '0;
    end else begin
      IN_FUNCS <= func_next;
      USER_OUT <= uout_next;
    end
  end
endmodule
`default_nettype wire

/* File: vio_router_checker.sv */
`default_nettype none
module vio_router_checker (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [255:0] IN_FUNCS,
  input wire logic [1:0] USER_OUT,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // Settings words are known good, far places must be refused
  wire logic good = PADDR <= 8'h14 && PADDR[1:0] == 2'h0;
  wire logic bad = PADDR > 8'h23;
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  ////////////////////////////////
  rdy_a: assert property (setup_s |=> PREADY) else $error("no ready");
  rdy_once_a: assert property (PREADY |=> !PREADY) else $error("long ready");
  rdy_idle_a: assert property (!PSEL |=> !PREADY) else $error("stray ready");
  err_bad_a: assert property (setup_s ##0 bad |=> PSLVERR) else $error("no error");
  err_ok_a: assert property (setup_s ##0 good |=> !PSLVERR) else $error("error");
  rd_zero_a: assert property (setup_s ##0 bad && !PWRITE |=> PRDATA == 32'h0)
    else $error("data");
  func_zero_a: assert property (IN_FUNCS[0] == 1'b0) else $error("code zero");
  rst_quiet_a: assert property (disable iff (1'b0) !RESET_N |=> USER_OUT == 2'h0)
    else $error("reset out");
endmodule
bind vio_router vio_router_checker u_chk (.*);
`default_nettype wire

/* File: tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import vio_router_pkg::*;
  logic CLK = 1'b0, RESET_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, err;
  logic [7:0] PADDR = 8'h00, f, s;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd, seed = 32'h1A;
  logic [255:0] OUT_SIGS = '0, IN_FUNCS, sig = '0;
  logic [18:0] cfg0, cfg1;
  logic [1:0] USER_OUT;
  logic PREADY, PSLVERR;
  int miscompares = 0, comparisons = 0, n;
  always #20 CLK = ~CLK;
  vio_router u_dut (.*);
  ////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("%0d checks, %0d mismatches", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Inversion per source first, then the AND or OR
  function automatic logic uo_exp(input logic [18:0] c, input logic [255:0] v);
    logic [1:0] p;
    p = {v[c[15:8]] ^ c[17], v[c[7:0]] ^ c[16]};
    return c[18] ? |p : &p;
  endfunction
  // Request held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, wr, a, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    {rd, err} = {PRDATA, PSLVERR};
    {PSEL, PENABLE} <= 2'b00;
  endtask
  task automatic drive(input logic [255:0] v);
    @(posedge CLK);
    OUT_SIGS <= v;
  endtask
  task automatic wait_chk(input int c, input logic [7:0] b, input logic e);
    repeat (c) @(posedge CLK);
    #1;
    check(IN_FUNCS[b], e);
  endtask
  ////////////////////////////////
  initial begin
    repeat (8) @(posedge CLK);
    RESET_N <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(rd, i < 4 ? 32'(VIN_RESET) : 32'(UOUT_RESET));
    end
    apb(1'b0, 8'h3C, 32'h0);
    check({rd[30:0], err}, 32'h1);
    $display("defaults done");
    // All inversion and combine modes on both outputs
    for (int k = 0; k < 8; k++) begin
      cfg0 = {3'(k), seed[15:0]};
      cfg1 = {3'(7 - k), seed[31:16]};
      apb(1'b1, UOUT_BASE, 32'(cfg0));
      apb(1'b1, UOUT_BASE + 8'h04, 32'(cfg1));
      repeat (12) begin
        seed = lfsr(seed);
        sig = {sig[223:0], seed};
        sig[128] = 1'b0;
        drive(sig);
        @(posedge CLK);
        #1;
        check(USER_OUT[0], uo_exp(cfg0, sig));
        check(USER_OUT[1], uo_exp(cfg1, sig));
      end
    end
    $display("user outputs done");
    // Each channel without dead time; odd ones inverted, upper two one-shot
    for (int ch = 0; ch < 4; ch++) begin
      seed = lfsr(seed);
      {s, f} = {1'b0, seed[14:8], seed[7:1], 1'b1};
      apb(1'b1, 8'(ch * 4), {6'h00, 2'(ch), 8'h00, s, f});
      drive(256'(ch[0]) << s);
      wait_chk(3, f, 1'b0);
      drive(256'(!ch[0]) << s);
      wait_chk(2, f, 1'b1);
      wait_chk(1, f, !ch[1]);
      apb(1'b1, 8'(ch * 4), 32'(VIN_RESET));
    end
    // One millisecond of dead time, then an immediate drop
    apb(1'b1, VIN_BASE + 8'h0C, 32'h00010205);
    drive(256'h4);
    for (n = 0; n < 26000 && IN_FUNCS[5] !== 1'b1; n++) @(posedge CLK);
    check(32'(n > 1 && n < 25004), 32'h1);
    drive(256'h0);
    wait_chk(2, 8'h05, 1'b0);
    $display("virtual inputs done");
    close_out();
  end
  // Watchdog at about 2.4 times the expected run
  initial begin
    #2400000;
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
